/* gam_pkg.sv */
// Notes on behaviour
// R1: at reset release the mode pin level is captured into mode bit 7.
// R2: mode register reads anytime; writes apply only for permitted mode transitions.
// R3: forbidden transition keeps mode and locks later mode writes, except in special mode.
// R4: while secured, every write to the mode register is ignored.
// R5: program, ram and data flash pages also expand debug addresses; debug reads/writes them.
// R6: debug local addresses expand with the same scheme as cpu local addresses.
// R7: seven-bit cpu global page plus local address forms a 23-bit global address.
// R8: cpu global page is used only during cpu global instructions.
// R9: cpu global address is page in bits 22:16, cpu local address in 15:0.
// R10: debug global page used only for firmware global commands or hardware commands.
// R11: hardware commands use debug local address; firmware commands use cpu local address.
// R12: ram ends just below 0x10_0000; lowest address is that minus ram size.
// R13: data flash starts at 0x10_0000 and ends at that plus data flash size.
// R14: program flash ends below 0x80_0000; lowest is that minus flash size.
// R15: resource sizes are fixed constants; software cannot move or resize them.
// R16: program flash size is its byte capacity as a hex quantity.
// R17: registers and lock reset to defaults on system reset; mode reloads from pin.
package gam_pkg;
    // mode register index and byte address (index times four)
    localparam logic [7:0] MODE_INDEX = 8'h0b;
    localparam logic [7:0] ADDR_MODE = 8'h2c;
    localparam logic [7:0] ADDR_PROG_PG = 8'h40;
    localparam logic [7:0] ADDR_RAM_PG = 8'h44;
    localparam logic [7:0] ADDR_DF_PG = 8'h48;
    localparam logic [7:0] ADDR_CPU_GIDX = 8'h4c;
    localparam logic [7:0] ADDR_DBG_GIDX = 8'h50;
    localparam logic [7:0] ADDR_STATUS = 8'h54;
    localparam int MODE_BIT = 7;
    localparam logic MODE_SPECIAL = 1'b0;
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_SECURE_BIT = 1;
    localparam int ST_MODE_BIT = 2;
    // page register reset values
    localparam logic [7:0] PROG_PG_RST = 8'hfe;
    localparam logic [7:0] RAM_PG_RST = 8'hfd;
    localparam logic [7:0] DF_PG_RST = 8'hfe;
    localparam logic [6:0] GIDX_RST = 7'h00;
    // debug port register selects
    localparam logic [2:0] DSEL_PROG = 3'h0;
    localparam logic [2:0] DSEL_RAM = 3'h1;
    localparam logic [2:0] DSEL_DF = 3'h2;
    localparam logic [2:0] DSEL_CPU_GIDX = 3'h3;
    localparam logic [2:0] DSEL_DBG_GIDX = 3'h4;
    // local address windows
    localparam logic [15:0] PWIN_LO = 16'h8000;
    localparam logic [15:0] PWIN_HI = 16'hbfff;
    localparam logic [15:0] RWIN_LO = 16'h1000;
    localparam logic [15:0] RWIN_HI = 16'h1fff;
    localparam logic [15:0] EWIN_LO = 16'h0800;
    localparam logic [15:0] EWIN_HI = 16'h0bff;
    localparam logic [6:0] UNPAGED_PAGE = 7'h7f;
    localparam logic [0:0] PFX_PROG = 1'b1;
    localparam logic [2:0] PFX_RAM = 3'b000;
    localparam logic [4:0] PFX_DFLASH = 5'b00100;
    // fixed resource sizes in bytes and boundaries
    localparam logic [22:0] RAM_BYTES = 23'h00_4000;
    localparam logic [22:0] DATA_FLASH_BYTES = 23'h00_8000;
    localparam logic [22:0] PROGRAM_FLASH_BYTES = 23'h04_0000;
    localparam logic [22:0] DF_BASE = 23'h10_0000;
    localparam logic [23:0] MAP_TOP = 24'h80_0000;
    localparam logic [22:0] RAM_LOW = DF_BASE - RAM_BYTES;
    localparam logic [22:0] DATA_FLASH_TOP = DF_BASE + DATA_FLASH_BYTES;
    localparam logic [22:0] FLASH_LOW = 23'(MAP_TOP - {1'b0, PROGRAM_FLASH_BYTES});
endpackage

/* gam_top.sv */
`timescale 1ns/1ps
module gam_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mode_select_pin,
    input wire logic secured,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_global,
    input wire logic [15:0] dbg_addr,
    input wire logic dbg_access,
    input wire logic dbg_hw_cmd,
    input wire logic dbg_fw_global,
    input wire logic dbg_reg_wr,
    input wire logic [2:0] dbg_reg_sel,
    input wire logic [7:0] dbg_reg_wdata,
    output logic [7:0] dbg_reg_rdata,
    output logic [22:0] global_addr,
    output logic ram_hit,
    output logic dflash_hit,
    output logic pflash_hit,
    output logic mode_out
);
    logic mode_bit;
    logic mode_lock;
    logic captured;
    logic [7:0] program_page_reg;
    logic [7:0] ram_page_reg;
    logic [7:0] data_flash_page_reg;
    logic [6:0] cpu_global_page_index;
    logic [6:0] debug_global_page_index;
    logic setup;
    logic wr_en;
    logic [31:0] next_rdata;
    logic next_err;
    logic [22:0] next_gaddr;
    logic mode_wr;
    logic mode_forbidden;
    logic next_ram_hit;
    logic next_dflash_hit;
    logic next_pflash_hit;

    // page register selected by a debug port select code
    function automatic logic [7:0] page_value(input logic [2:0] sel);
        if (sel == gam_pkg::DSEL_PROG) begin
            page_value = program_page_reg;
        end else if (sel == gam_pkg::DSEL_RAM) begin
            page_value = ram_page_reg;
        end else if (sel == gam_pkg::DSEL_DF) begin
            page_value = data_flash_page_reg;
        end else if (sel == gam_pkg::DSEL_CPU_GIDX) begin
            page_value = {1'b0, cpu_global_page_index};
        end else if (sel == gam_pkg::DSEL_DBG_GIDX) begin
            page_value = {1'b0, debug_global_page_index};
        end else begin
            page_value = 8'h00;
        end
    endfunction

    // next value of one page register: the debug port wins over the bus
    function automatic logic [7:0] next_page(input logic [7:0] cur, input logic [2:0] sel,
                                             input logic [7:0] addr);
        if (dbg_reg_wr && dbg_reg_sel == sel) begin
            next_page = dbg_reg_wdata;
        end else if (wr_en && paddr == addr) begin
            next_page = pwdata[7:0];
        end else begin
            next_page = cur;
        end
    endfunction

    // half-open range test on the global map, widened so the top can be 0x80_0000
    function automatic logic in_range(input logic [22:0] a, input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = {1'b0, a} >= lo && {1'b0, a} < hi;
    endfunction

    // local to global expansion shared by cpu and debug paths
    function automatic logic [22:0] expand(input logic [15:0] a, input logic [7:0] pp,
                                           input logic [7:0] rp, input logic [7:0] ep);
        if (a >= gam_pkg::PWIN_LO && a <= gam_pkg::PWIN_HI) begin
            expand = {gam_pkg::PFX_PROG, pp, a[13:0]};
        end else if (a >= gam_pkg::RWIN_LO && a <= gam_pkg::RWIN_HI) begin
            expand = {gam_pkg::PFX_RAM, rp, a[11:0]};
        end else if (a >= gam_pkg::EWIN_LO && a <= gam_pkg::EWIN_HI) begin
            expand = {gam_pkg::PFX_DFLASH, ep, a[9:0]};
        end else begin
            expand = {gam_pkg::UNPAGED_PAGE, a};
        end
    endfunction

    // apb phases: setup answered by pready in the following access cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    // zero-wait answer flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // read decode and error for unmapped addresses
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (paddr == gam_pkg::ADDR_MODE) begin
            next_rdata[gam_pkg::MODE_BIT] = mode_bit; // [R2]
        end else if (paddr == gam_pkg::ADDR_PROG_PG) begin
            next_rdata[7:0] = page_value(gam_pkg::DSEL_PROG);
        end else if (paddr == gam_pkg::ADDR_RAM_PG) begin
            next_rdata[7:0] = page_value(gam_pkg::DSEL_RAM);
        end else if (paddr == gam_pkg::ADDR_DF_PG) begin
            next_rdata[7:0] = page_value(gam_pkg::DSEL_DF);
        end else if (paddr == gam_pkg::ADDR_CPU_GIDX) begin
            next_rdata[7:0] = page_value(gam_pkg::DSEL_CPU_GIDX);
        end else if (paddr == gam_pkg::ADDR_DBG_GIDX) begin
            next_rdata[7:0] = page_value(gam_pkg::DSEL_DBG_GIDX);
        end else if (paddr == gam_pkg::ADDR_STATUS) begin
            next_rdata[gam_pkg::ST_LOCK_BIT] = mode_lock;
            next_rdata[gam_pkg::ST_SECURE_BIT] = secured;
            next_rdata[gam_pkg::ST_MODE_BIT] = mode_bit;
        end else begin
            next_err = 1'b1;
        end
    end

    // read data captured at setup, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        end
    end

    // error flag captured at setup for unmapped addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= next_err;
        end
    end

    // a mode write reaches the bits only once captured and while unsecured
    assign mode_wr = wr_en && paddr == gam_pkg::ADDR_MODE && captured && !secured; // [R4]
    // normal to special is the one transition that is never allowed
    assign mode_forbidden = mode_bit != gam_pkg::MODE_SPECIAL
                            && pwdata[gam_pkg::MODE_BIT] == gam_pkg::MODE_SPECIAL;

    // mode bit: special during reset, captured once from the pin at release, then write-controlled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured <= 1'b0;
            mode_bit <= gam_pkg::MODE_SPECIAL;
        end else if (!captured) begin
            captured <= 1'b1;
            mode_bit <= mode_select_pin; // [R1] [R17]
        end else if (mode_wr && !mode_forbidden) begin
            // special mode ignores the lock
            if (mode_bit == gam_pkg::MODE_SPECIAL || !mode_lock) begin
                mode_bit <= pwdata[gam_pkg::MODE_BIT]; // [R2] [R3]
            end
        end
    end

    // lock: set by a forbidden request, cleared only by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_lock <= 1'b0; // [R17]
        end else if (mode_wr && mode_forbidden) begin
            mode_lock <= 1'b1; // [R3]
        end
    end

    // mode output mirrors the pin until captured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_out <= gam_pkg::MODE_SPECIAL;
        end else begin
            mode_out <= captured ? mode_bit : mode_select_pin; // [R1]
        end
    end

    // program page register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_page_reg <= gam_pkg::PROG_PG_RST; // [R17]
        end else begin
            program_page_reg <= next_page(program_page_reg, gam_pkg::DSEL_PROG,
                                          gam_pkg::ADDR_PROG_PG); // [R5]
        end
    end

    // ram page register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_page_reg <= gam_pkg::RAM_PG_RST; // [R17]
        end else begin
            ram_page_reg <= next_page(ram_page_reg, gam_pkg::DSEL_RAM,
                                      gam_pkg::ADDR_RAM_PG); // [R5]
        end
    end

    // data flash page register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_flash_page_reg <= gam_pkg::DF_PG_RST; // [R17]
        end else begin
            data_flash_page_reg <= next_page(data_flash_page_reg, gam_pkg::DSEL_DF,
                                             gam_pkg::ADDR_DF_PG); // [R5]
        end
    end

    // cpu global page index, seven bits kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_global_page_index <= gam_pkg::GIDX_RST; // [R17]
        end else begin
            cpu_global_page_index <= 7'(next_page({1'b0, cpu_global_page_index},
                                     gam_pkg::DSEL_CPU_GIDX, gam_pkg::ADDR_CPU_GIDX)); // [R7]
        end
    end

    // debug global page index, seven bits kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_global_page_index <= gam_pkg::GIDX_RST; // [R17]
        end else begin
            debug_global_page_index <= 7'(next_page({1'b0, debug_global_page_index},
                                       gam_pkg::DSEL_DBG_GIDX, gam_pkg::ADDR_DBG_GIDX)); // [R10]
        end
    end

    // debug port read-back of page registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_reg_rdata <= 8'h00;
        end else begin
            dbg_reg_rdata <= page_value(dbg_reg_sel); // [R5]
        end
    end

    // global address source selection
    always_comb begin
        if (dbg_hw_cmd) begin
            next_gaddr = {debug_global_page_index, dbg_addr}; // [R10] [R11]
        end else if (dbg_fw_global) begin
            next_gaddr = {debug_global_page_index, cpu_addr}; // [R10] [R11]
        end else if (cpu_global) begin
            next_gaddr = {cpu_global_page_index, cpu_addr}; // [R7] [R8] [R9]
        end else if (dbg_access) begin
            next_gaddr = expand(dbg_addr, program_page_reg, ram_page_reg,
                                data_flash_page_reg); // [R5] [R6]
        end else begin
            next_gaddr = expand(cpu_addr, program_page_reg, ram_page_reg,
                                data_flash_page_reg); // [R8]
        end
    end

    // fixed resource windows; sizes are constants, never software-set
    assign next_ram_hit = in_range(next_gaddr, {1'b0, gam_pkg::RAM_LOW},
                                   {1'b0, gam_pkg::DF_BASE}); // [R12] [R15]
    assign next_dflash_hit = in_range(next_gaddr, {1'b0, gam_pkg::DF_BASE},
                                      {1'b0, gam_pkg::DATA_FLASH_TOP}); // [R13]
    assign next_pflash_hit = in_range(next_gaddr, {1'b0, gam_pkg::FLASH_LOW},
                                      gam_pkg::MAP_TOP); // [R14] [R16]

    // registered global address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_addr <= 23'h00_0000;
        end else begin
            global_addr <= next_gaddr;
        end
    end

    // ram region flag, aligned with global_addr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_hit <= 1'b0;
        end else begin
            ram_hit <= next_ram_hit;
        end
    end

    // data flash region flag, aligned with global_addr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dflash_hit <= 1'b0;
        end else begin
            dflash_hit <= next_dflash_hit;
        end
    end

    // program flash region flag, aligned with global_addr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pflash_hit <= 1'b0;
        end else begin
            pflash_hit <= next_pflash_hit;
        end
    end
endmodule // gam_top

/* gam_chk_sva.sv */
`timescale 1ns/1ps
module gam_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic secured,
    input wire logic mode_out,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_global,
    input wire logic [15:0] dbg_addr,
    input wire logic dbg_hw_cmd,
    input wire logic dbg_fw_global,
    input wire logic [22:0] global_addr,
    input wire logic ram_hit,
    input wire logic dflash_hit,
    input wire logic pflash_hit
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase of a mode register write
    sequence s_mode_wr;
        psel && penable && pwrite && paddr == gam_pkg::ADDR_MODE;
    endsequence
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_sec; s_mode_wr ##0 secured |=> $stable(mode_out) [*2]; endproperty
    a_sec: assert property (p_sec) else $error("secured mode write took effect");
    property p_lock; s_mode_wr ##0 (!secured && mode_out && !pwdata[7]) |=> mode_out [*2];
    endproperty
    a_lock: assert property (p_lock) else $error("forbidden mode change");
    property p_cglb;
        cpu_global && !dbg_hw_cmd && !dbg_fw_global |=> global_addr[15:0] == $past(cpu_addr);
    endproperty
    a_cglb: assert property (p_cglb) else $error("cpu global low bits wrong");
    property p_hw; dbg_hw_cmd |=> global_addr[15:0] == $past(dbg_addr); endproperty
    a_hw: assert property (p_hw) else $error("debug hw address wrong");
    property p_fw;
        dbg_fw_global && !dbg_hw_cmd |=> global_addr[15:0] == $past(cpu_addr);
    endproperty
    a_fw: assert property (p_fw) else $error("debug fw address wrong");
    property p_ram;
        ram_hit |-> global_addr >= gam_pkg::RAM_LOW && global_addr < gam_pkg::DF_BASE;
    endproperty
    a_ram: assert property (p_ram) else $error("ram hit outside ram");
    property p_df;
        dflash_hit |-> global_addr >= gam_pkg::DF_BASE && global_addr < gam_pkg::DATA_FLASH_TOP;
    endproperty
    a_df: assert property (p_df) else $error("data flash hit outside range");
    property p_pf; pflash_hit |-> global_addr >= gam_pkg::FLASH_LOW; endproperty
    a_pf: assert property (p_pf) else $error("flash hit below flash");
endmodule // gam_chk

/* gam_far.sv */
`timescale 1ns/1ps
module gam_far (
    input wire logic pclk,
    input wire logic [2:0] kind,
    input wire logic [15:0] addr,
    output logic [15:0] cpu_addr,
    output logic cpu_global,
    output logic [15:0] dbg_addr,
    output logic dbg_access,
    output logic dbg_hw_cmd,
    output logic dbg_fw_global
);
    // start from known buses so a released bus toggles instead of staying unknown
    initial begin
        cpu_addr = 16'h0;
        dbg_addr = 16'h0;
    end
    // kind: 0 cpu paged, 1 cpu global, 2 debug local, 3 firmware global, 4 hw command
    always @(posedge pclk) begin
        cpu_addr <= (kind == 3'h2 || kind == 3'h4) ? ~cpu_addr : addr;
        cpu_global <= kind == 3'h1;
        dbg_addr <= (kind == 3'h2 || kind == 3'h4) ? addr : ~dbg_addr;
        dbg_access <= kind == 3'h2;
        dbg_hw_cmd <= kind == 3'h4;
        dbg_fw_global <= kind == 3'h3;
    end
endmodule // gam_far

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [2:0] k; logic [15:0] a; logic [22:0] g; logic [2:0] h;} gam_row_t;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic mode_select_pin = 1'h1, secured = 1'h0, dbg_reg_wr = 1'h0;
    logic [7:0] paddr = 8'h0, dbg_reg_wdata = 8'h0, dbg_reg_rdata;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] dbg_reg_sel = 3'h0, kind = 3'h0;
    logic [15:0] addr = 16'h0, cpu_addr, dbg_addr;
    logic pready, pslverr, cpu_global, dbg_access, dbg_hw_cmd, dbg_fw_global, err;
    logic ram_hit, dflash_hit, pflash_hit, mode_out;
    logic [22:0] global_addr;
    int mismatches = 0, checks_done = 0;
    // cpu global index 0x10 and debug global index 0x7c are written before the rows run
    gam_row_t rows [9] = '{
        {3'h0, 16'h8123, {1'h1, 8'hfe, 14'h0123}, 3'h1}, {3'h2, 16'h8123, {1'h1, 8'hfe, 14'h0123}, 3'h1},
        {3'h1, 16'h7fff, 23'h10_7fff, 3'h2}, {3'h1, 16'h8000, 23'h10_8000, 3'h0},
        {3'h3, 16'h0000, 23'h7c_0000, 3'h1}, {3'h4, 16'hffff, 23'h7c_ffff, 3'h1},
        {3'h0, 16'h1010, 23'h0f_d010, 3'h4}, {3'h2, 16'h1fff, 23'h0f_dfff, 3'h4},
        {3'h0, 16'h4000, 23'h7f_4000, 3'h1}};
    always #2.5 pclk = ~pclk;
    gam_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .mode_select_pin, .secured, .cpu_addr, .cpu_global, .dbg_addr, .dbg_access,
        .dbg_hw_cmd, .dbg_fw_global, .dbg_reg_wr, .dbg_reg_sel, .dbg_reg_wdata, .dbg_reg_rdata,
        .global_addr, .ram_hit, .dflash_hit, .pflash_hit, .mode_out);
    gam_far i_far (.pclk, .kind, .addr, .cpu_addr, .cpu_global, .dbg_addr, .dbg_access,
        .dbg_hw_cmd, .dbg_fw_global);
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer; read data and error are taken at the ready edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
        if (n >= 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rst(logic pin, logic sec);
        presetn <= 1'h0;
        mode_select_pin <= pin;
        secured <= sec;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
    endtask
    task automatic run(logic [2:0] k, logic [15:0] a);
        kind <= k;
        addr <= a;
        repeat (4) @(posedge pclk);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #20000;
        mismatches++;
        end_sim;
    end
    initial begin
        rst(1'h1, 1'h0);
        chk("mode_out", 32'h1, 32'(mode_out));
        apb(1'h0, gam_pkg::ADDR_MODE, 32'h0);
        chk("mode_bit", 32'h1, 32'(rd[7]));
        apb(1'h0, gam_pkg::ADDR_RAM_PG, 32'h0);
        chk("ram_page", 32'hfd, rd);
        apb(1'h1, gam_pkg::ADDR_CPU_GIDX, 32'h10);
        apb(1'h1, gam_pkg::ADDR_DBG_GIDX, 32'h7c);
        foreach (rows[i]) begin
            run(rows[i].k, rows[i].a);
            chk("global_addr", 32'(rows[i].g), 32'(global_addr));
            chk("hits", 32'(rows[i].h), 32'({ram_hit, dflash_hit, pflash_hit}));
        end
        dbg_reg_wr <= 1'h1;
        dbg_reg_sel <= gam_pkg::DSEL_PROG;
        dbg_reg_wdata <= 8'h21;
        @(posedge pclk);
        dbg_reg_wr <= 1'h0;
        repeat (2) @(posedge pclk);
        chk("dbg_rdata", 32'h21, 32'(dbg_reg_rdata));
        run(3'h2, 16'hbfff);
        chk("dbg_paged", 32'({1'h1, 8'h21, 14'h3fff}), 32'(global_addr));
        apb(1'h0, 8'hfc, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        apb(1'h1, gam_pkg::ADDR_MODE, 32'h0);
        repeat (3) @(posedge pclk);
        chk("mode_kept", 32'h1, 32'(mode_out));
        apb(1'h0, gam_pkg::ADDR_STATUS, 32'h0);
        chk("lock", 32'h1, 32'(rd[0]));
        rst(1'h0, 1'h0);
        chk("mode_pin0", 32'h0, 32'(mode_out));
        apb(1'h0, gam_pkg::ADDR_PROG_PG, 32'h0);
        chk("prog_page", 32'hfe, rd);
        apb(1'h1, gam_pkg::ADDR_MODE, 32'h80);
        repeat (3) @(posedge pclk);
        chk("mode_up", 32'h1, 32'(mode_out));
        rst(1'h0, 1'h1);
        apb(1'h1, gam_pkg::ADDR_MODE, 32'h80);
        repeat (3) @(posedge pclk);
        chk("mode_sec", 32'h0, 32'(mode_out));
        end_sim;
    end
endmodule // tb_top
bind gam_top gam_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .secured, .mode_out, .cpu_addr, .cpu_global, .dbg_addr, .dbg_hw_cmd,
    .dbg_fw_global, .global_addr, .ram_hit, .dflash_hit, .pflash_hit);
